//--- include/radio_spi_map.vh
/*
  constants for the radio serial command port: command codes, answer bytes,
  buffer sizes and timing figures. the clock rate is set here: CLK_MHZ is 250.
*/
`ifndef RADIO_SPI_MAP_VH
`define RADIO_SPI_MAP_VH

`define CLK_MHZ 250

`define CMD_READ_BUFF 8'h44
`define CMD_FSR_A 8'h50
`define CMD_FSR_B 8'h51
`define CMD_FSR_C 8'h53
`define CMD_FSR_D 8'h57
`define CMD_TX_WRITE 8'h66
`define CMD_RX_READ 8'h77
`define CMD_INT_STATUS 8'h20
`define CMD_CHIP_STATUS 8'h23

`define CTS_READY 8'hff
`define CTS_PENDING 8'h00

`define RSP_BYTES 16
`define FSR_COUNT 4
`define FIFO_AW 6

`define POR_TIME_US 5000
`define SD_TRX_TIME_US 15000
`define RDY_TX_TIME_US 126
`define RDY_RX_TIME_US 122

`endif

//--- src/radio_spi_command_port.v
/*
  serial command port of the radio: command/answer handshake with a readiness byte,
  answer buffer, fast status reads, transmit and receive fifos, state sequencer
  and power-on wake. assumes an spi mode 0 master far slower than mclk_i and a
  command core on mclk_i that answers each accepted command with rsp_done_i.
*/
// Functional notes
// R01 - while an answer is fetched readiness reads 0x00; ready reads 0xff
// R02 - host polls with 0x44 then eight clocks sampling the readiness byte
// R03 - readiness 0x00 means pending; host repeats whole poll until 0xff
// R04 - on 0xff the answer bytes follow in the same transaction
// R05 - answer kept until next command; each read restarts at byte zero
// R06 - up to 16 answer bytes, then the same 16 repeat cyclically
// R07 - bytes past the answer length are undefined, no error raised
// R08 - chip select high then low resets the serial interface by itself
// R09 - four fast status registers each show the item their select picks
// R10 - fast status read: code, eight clocks, register value out
// R11 - further bytes give following registers, wrapping after the fourth
// R12 - fast status reads never release the interrupt output
// R13 - 64-byte fifos; code 0x66 then up to 64 bytes loads transmit data
// R14 - code 0x77 then clocked bytes shift receive fifo data out
// R15 - transmit overflow or receive underflow sets range error, maybe interrupt
// R16 - range error cleared only by a status command answer read; code also clears it while shutdown is high
// R17 - sequencer waits 15 ms from shutdown, 126 us ready-tx, 122 us ready-rx
// R18 - sequencer reaches tx or rx from any state, returns to ready after; code ignores requests while in tune or with shutdown high
// R19 - host holds chip select high during sleep
// R20 - after shutdown falls, 5 ms power-on reset rejects serial commands
// R21 - ready pin low during power-on reset, high once commands are accepted
// R22 - wake done is shown by readiness, interrupt or ready pin
// R23 - a command while busy is ignored and sets the overrun error flag
// R24 - fast status codes 0x50, 0x51, 0x53, 0x57 start at a, b, c, d
// R25 - on known readiness host reads 0x44, readiness byte, then answer
`timescale 1ns/1ps
`default_nettype none
`include "radio_spi_map.vh"

module radio_spi_command_port #(
  parameter [21:0] POR_CYCLES = `POR_TIME_US * `CLK_MHZ,
  parameter [21:0] SD_TRX_CYCLES = `SD_TRX_TIME_US * `CLK_MHZ,
  parameter [21:0] RDY_TX_CYCLES = `RDY_TX_TIME_US * `CLK_MHZ,
  parameter [21:0] RDY_RX_CYCLES = `RDY_RX_TIME_US * `CLK_MHZ,
  parameter AW = `FIFO_AW
) (
  input wire mclk_i,
  input wire rstn_i,
  input wire ce_i,
  input wire shutdown_pin_i,
  input wire chip_select_n_i,
  input wire spi_clk_i,
  input wire serial_data_in_i,
  output wire serial_data_out_o,
  output wire serial_data_out_oe_o,
  output wire irq_out_low_o,
  output wire ready_pin_one_o,
  output wire cmd_valid_o,
  output wire [7:0] cmd_byte_o,
  output wire param_valid_o,
  output wire [7:0] param_byte_o,
  input wire rsp_done_i,
  input wire [127:0] rsp_data_i,
  input wire [31:0] fast_status_select_i,
  input wire [63:0] status_items_i,
  input wire ext_irq_i,
  input wire fifo_err_en_i,
  input wire cmd_err_en_i,
  output wire fifo_err_o,
  output wire cmd_err_o,
  input wire tx_pop_i,
  output wire [7:0] tx_data_o,
  output wire tx_empty_o,
  input wire rx_push_i,
  input wire [7:0] rx_data_i,
  output wire rx_full_o,
  input wire tx_req_i,
  input wire rx_req_i,
  input wire trx_done_i,
  output wire [4:0] radio_state_o
);

  localparam [5:0] M_IDLE = 6'h01, M_BUF = 6'h02, M_FSR = 6'h04;
  localparam [5:0] M_TXW = 6'h08, M_RXR = 6'h10, M_PAR = 6'h20;
  localparam [4:0] S_SD = 5'h01, S_RDY = 5'h02, S_TUNE = 5'h04, S_TX = 5'h08, S_RX = 5'h10;

  // picks the status item that one fast status register's select names
  function [7:0] fsr_val;
    input [1:0] idx;
    input [31:0] picks;
    input [63:0] items;
    reg [2:0] item;
    begin
      item = picks[{idx, 3'b000} +: 3];
      fsr_val = items[{item, 3'b000} +: 8];
    end
  endfunction

  reg [3:0] s1_ff, s2_ff, rsp_ptr_ff;
  reg [2:0] bit_cnt_ff;
  reg [7:0] in_sr_ff, out_sr_ff, cmd_byte_ff, param_byte_ff, tx_data_ff;
  reg [5:0] mode_ff;
  reg [1:0] fsr_ptr_ff;
  reg [127:0] rsp_ff;
  reg [21:0] por_cnt_ff, seq_cnt_ff;
  reg [4:0] seq_ff;
  reg [AW:0] tx_wr_ff, tx_rd_ff, rx_wr_ff, rx_rd_ff;
  reg sclk_d_ff, oe_ff, first_ff, rd_ok_ff, busy_ff, status_cmd_ff, fifo_err_ff, cmd_err_ff;
  reg cmd_valid_ff, param_valid_ff, por_done_ff, tgt_tx_ff, rx_short_ff;
  reg [7:0] tx_mem [0:(1<<AW)-1];
  reg [7:0] rx_mem [0:(1<<AW)-1];
  reg [7:0] nxt_out;

  wire sdn_s = s2_ff[0];
  wire cs_s = s2_ff[1];
  wire sclk_s = s2_ff[2];
  wire sdi_s = s2_ff[3];
  wire rise = sclk_s & ~sclk_d_ff;
  wire fall = ~sclk_s & sclk_d_ff;
  // R20 commands rejected until reset ends
  wire sel = ~cs_s & por_done_ff;
  wire [7:0] nxt_byte = {in_sr_ff[6:0], sdi_s};
  wire byte_done = sel & rise & (bit_cnt_ff == 3'h7);
  wire is_fsr = (nxt_byte == `CMD_FSR_A) | (nxt_byte == `CMD_FSR_B) |
                (nxt_byte == `CMD_FSR_C) | (nxt_byte == `CMD_FSR_D);
  wire is_direct = is_fsr | (nxt_byte == `CMD_READ_BUFF) |
                   (nxt_byte == `CMD_TX_WRITE) | (nxt_byte == `CMD_RX_READ);
  // R24 start register per code
  wire [1:0] fsr_start = (nxt_byte == `CMD_FSR_B) ? 2'h1 :
                         (nxt_byte == `CMD_FSR_C) ? 2'h2 :
                         (nxt_byte == `CMD_FSR_D) ? 2'h3 : 2'h0;
  wire new_cmd = byte_done & first_ff & ~is_direct;
  wire tx_full = (tx_wr_ff ^ tx_rd_ff) == {1'b1, {AW{1'b0}}};
  wire tx_empty = tx_wr_ff == tx_rd_ff;
  wire rx_full = (rx_wr_ff ^ rx_rd_ff) == {1'b1, {AW{1'b0}}};
  wire rx_empty = rx_wr_ff == rx_rd_ff;
  wire tx_wr_byte = byte_done & ~first_ff & (mode_ff == M_TXW);
  wire rx_rd_byte = byte_done & ((first_ff & (nxt_byte == `CMD_RX_READ)) |
                    (~first_ff & (mode_ff == M_RXR)));
  wire tx_push = ce_i & tx_wr_byte & ~tx_full;
  wire rx_pop = rx_rd_byte & ~rx_empty;
  wire rx_push = ce_i & rx_push_i & ~rx_full;
  wire tx_pop = tx_pop_i & ~tx_empty;
  // R15 overflow or underflow
  wire range_err = (tx_wr_byte & tx_full) | (rx_short_ff & sel & rise & (bit_cnt_ff == 3'h0));
  // R23 overrun while busy
  wire overrun = new_cmd & busy_ff;
  // R16 cleared by reading a status answer
  wire clr_flags = byte_done & ~first_ff & (mode_ff == M_BUF) & rd_ok_ff &
                   (rsp_ptr_ff == 4'h0) & status_cmd_ff;

  always @* begin
    nxt_out = 8'h00;
    if (first_ff) begin
      if (nxt_byte == `CMD_READ_BUFF) begin
        // R01 R03 readiness byte value
        nxt_out = busy_ff ? `CTS_PENDING : `CTS_READY;
      end else if (is_fsr) begin
        // R09 R10 selected status item
        nxt_out = fsr_val(fsr_start, fast_status_select_i, status_items_i);
      end else if (nxt_byte == `CMD_RX_READ) begin
        nxt_out = rx_mem[rx_rd_ff[AW-1:0]];
      end
    end else begin
      case (mode_ff)
        // R04 R25 answer follows readiness; R07 bytes past the answer are whatever is held
        M_BUF: nxt_out = rd_ok_ff ? rsp_ff[{rsp_ptr_ff, 3'b000} +: 8] : `CTS_PENDING;
        M_FSR: nxt_out = fsr_val(fsr_ptr_ff, fast_status_select_i, status_items_i);
        M_RXR: nxt_out = rx_mem[rx_rd_ff[AW-1:0]];
        default: nxt_out = 8'h00;
      endcase
    end
  end

  // fifo storage has no reset; pointers alone define content
  always @(posedge mclk_i) begin
    if (tx_push) begin
      tx_mem[tx_wr_ff[AW-1:0]] <= nxt_byte;
    end
    if (rx_push) begin
      rx_mem[rx_wr_ff[AW-1:0]] <= rx_data_i;
    end
  end

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_ff <= 4'h3;
      s2_ff <= 4'h3;
      sclk_d_ff <= 1'b0;
      bit_cnt_ff <= 3'h0;
      in_sr_ff <= 8'h00;
      out_sr_ff <= 8'h00;
      oe_ff <= 1'b0;
      first_ff <= 1'b1;
      mode_ff <= M_IDLE;
      rd_ok_ff <= 1'b0;
      rsp_ptr_ff <= 4'h0;
      fsr_ptr_ff <= 2'h0;
      busy_ff <= 1'b0;
      status_cmd_ff <= 1'b0;
      rsp_ff <= 128'h0;
      fifo_err_ff <= 1'b0;
      cmd_err_ff <= 1'b0;
      cmd_valid_ff <= 1'b0;
      cmd_byte_ff <= 8'h00;
      param_valid_ff <= 1'b0;
      param_byte_ff <= 8'h00;
      por_cnt_ff <= 22'h0;
      por_done_ff <= 1'b0;
      seq_ff <= S_SD;
      tgt_tx_ff <= 1'b0;
      seq_cnt_ff <= 22'h0;
      tx_wr_ff <= {(AW+1){1'b0}};
      tx_rd_ff <= {(AW+1){1'b0}};
      rx_wr_ff <= {(AW+1){1'b0}};
      rx_rd_ff <= {(AW+1){1'b0}};
      tx_data_ff <= 8'h00;
      rx_short_ff <= 1'b0;
    end else if (ce_i) begin
      s1_ff <= {serial_data_in_i, spi_clk_i, chip_select_n_i, shutdown_pin_i};
      s2_ff <= s1_ff;
      sclk_d_ff <= sclk_s;
      oe_ff <= sel;
      cmd_valid_ff <= new_cmd & ~busy_ff;
      param_valid_ff <= 1'b0;
      // R20 power-on reset timer
      if (sdn_s) begin
        por_cnt_ff <= 22'h0;
        por_done_ff <= 1'b0;
      end else if (!por_done_ff) begin
        por_cnt_ff <= por_cnt_ff + 22'h1;
        por_done_ff <= por_cnt_ff == POR_CYCLES - 22'h1;
      end
      // R08 chip select high restarts framing
      if (!sel) begin
        bit_cnt_ff <= 3'h0;
        out_sr_ff <= 8'h00;
        first_ff <= 1'b1;
        mode_ff <= M_IDLE;
      end else begin
        if (rise) begin
          in_sr_ff <= nxt_byte;
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
        // the edge ending a byte loads, so the next falling edge must not shift
        if (fall && bit_cnt_ff != 3'h0) begin
          out_sr_ff <= {out_sr_ff[6:0], 1'b0};
        end
        if (byte_done) begin
          out_sr_ff <= nxt_out;
          first_ff <= 1'b0;
          if (first_ff) begin
            mode_ff <= M_IDLE;
            if (nxt_byte == `CMD_READ_BUFF) begin
              mode_ff <= M_BUF;
              // R05 every read starts at byte zero
              rsp_ptr_ff <= 4'h0;
              rd_ok_ff <= ~busy_ff;
            end else if (is_fsr) begin
              mode_ff <= M_FSR;
              fsr_ptr_ff <= fsr_start + 2'h1;
            end else if (nxt_byte == `CMD_TX_WRITE) begin
              mode_ff <= M_TXW;
            end else if (nxt_byte == `CMD_RX_READ) begin
              mode_ff <= M_RXR;
            end else if (!busy_ff) begin
              mode_ff <= M_PAR;
              cmd_byte_ff <= nxt_byte;
            end
          end else if (mode_ff == M_BUF) begin
            if (rd_ok_ff) begin
              // R06 wraps after 16
              rsp_ptr_ff <= rsp_ptr_ff + 4'h1;
            end
          end else if (mode_ff == M_FSR) begin
            // R11 wraps after the fourth
            fsr_ptr_ff <= fsr_ptr_ff + 2'h1;
          end else if (mode_ff == M_PAR) begin
            param_valid_ff <= 1'b1;
            param_byte_ff <= nxt_byte;
          end
        end
      end
      // R01 busy from accept until answer is fetched
      if (new_cmd && !busy_ff) begin
        busy_ff <= 1'b1;
        rsp_ff <= 128'h0;
        status_cmd_ff <= (nxt_byte == `CMD_INT_STATUS) | (nxt_byte == `CMD_CHIP_STATUS);
      end else if (rsp_done_i || sdn_s) begin
        busy_ff <= 1'b0;
        if (rsp_done_i) begin
          rsp_ff <= rsp_data_i;
        end
      end
      // R15 set wins over the clear
      fifo_err_ff <= ~sdn_s & (range_err | (fifo_err_ff & ~clr_flags));
      cmd_err_ff <= ~sdn_s & (overrun | (cmd_err_ff & ~clr_flags));
      // R13 fifo pointers
      tx_wr_ff <= tx_wr_ff + {{AW{1'b0}}, tx_push};
      if (tx_pop) begin
        tx_rd_ff <= tx_rd_ff + 1'b1;
        tx_data_ff <= tx_mem[tx_rd_ff[AW-1:0]];
      end
      rx_wr_ff <= rx_wr_ff + {{AW{1'b0}}, rx_push};
      // R14 bytes leave the receive fifo
      rx_rd_ff <= rx_rd_ff + {{AW{1'b0}}, rx_pop};
      rx_short_ff <= sel & (rx_rd_byte ? rx_empty : rx_short_ff);
      // R18 automatic sequencer
      if (sdn_s) begin
        seq_ff <= S_SD;
      end else begin
        case (seq_ff)
          S_SD: begin
            if (tx_req_i || rx_req_i) begin
              // R17 shutdown to tx or rx
              seq_ff <= S_TUNE;
              tgt_tx_ff <= tx_req_i;
              seq_cnt_ff <= SD_TRX_CYCLES - 22'h1;
            end else if (por_done_ff) begin
              seq_ff <= S_RDY;
            end
          end
          S_TUNE: begin
            if (seq_cnt_ff == 22'h0) begin
              seq_ff <= tgt_tx_ff ? S_TX : S_RX;
            end else begin
              seq_cnt_ff <= seq_cnt_ff - 22'h1;
            end
          end
          S_RDY, S_TX, S_RX: begin
            if (trx_done_i && seq_ff != S_RDY) begin
              seq_ff <= S_RDY;
            end else if ((tx_req_i && seq_ff != S_TX) || (rx_req_i && !tx_req_i &&
                         seq_ff != S_RX)) begin
              // R17 ready to tx or rx times
              seq_ff <= S_TUNE;
              tgt_tx_ff <= tx_req_i;
              seq_cnt_ff <= tx_req_i ? RDY_TX_CYCLES - 22'h1 : RDY_RX_CYCLES - 22'h1;
            end
          end
          default: seq_ff <= S_SD;
        endcase
      end
    end
  end

  assign serial_data_out_o = out_sr_ff[7] & oe_ff;
  assign serial_data_out_oe_o = oe_ff;
  // R12 ext_irq_i and the enabled flags, cleared by a status answer read, drive the line
  assign irq_out_low_o = ~(ext_irq_i | (fifo_err_ff & fifo_err_en_i) |
                           (cmd_err_ff & cmd_err_en_i));
  // R21 R22 low during reset and while busy
  assign ready_pin_one_o = por_done_ff & ~busy_ff;
  assign cmd_valid_o = cmd_valid_ff;
  assign cmd_byte_o = cmd_byte_ff;
  assign param_valid_o = param_valid_ff;
  assign param_byte_o = param_byte_ff;
  assign fifo_err_o = fifo_err_ff;
  assign cmd_err_o = cmd_err_ff;
  assign tx_data_o = tx_data_ff;
  assign tx_empty_o = tx_empty;
  assign rx_full_o = rx_full;
  assign radio_state_o = seq_ff;

endmodule // radio_spi_command_port
`default_nettype wire

//--- test/radio_spi_command_port_asserts.sv
/*
  pin level checks for the serial command port, bound into the port module.
  assumes the port module's own names and a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module radio_spi_port_checker (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic shutdown_pin_i,
  input wire logic chip_select_n_i,
  input wire logic serial_data_out_o,
  input wire logic serial_data_out_oe_o,
  input wire logic irq_out_low_o,
  input wire logic ready_pin_one_o,
  input wire logic cmd_valid_o,
  input wire logic rsp_done_i,
  input wire logic fifo_err_en_i,
  input wire logic cmd_err_en_i,
  input wire logic fifo_err_o,
  input wire logic cmd_err_o,
  input wire logic trx_done_i,
  input wire logic [4:0] radio_state_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  sd_ready_low_a: assert property (shutdown_pin_i [*6] |-> !ready_pin_one_o)
    else $error("ready pin high in shutdown");
  sd_state_a: assert property (shutdown_pin_i [*6] |-> radio_state_o == 5'h01)
    else $error("state not shutdown");
  desel_oe_a: assert property (chip_select_n_i [*6] |-> !serial_data_out_oe_o)
    else $error("data out enabled while deselected");
  desel_sdo_a: assert property (chip_select_n_i [*6] |-> !serial_data_out_o)
    else $error("data out high while deselected");
  busy_ready_a: assert property (cmd_valid_o ##1 !rsp_done_i [*2] |-> !ready_pin_one_o)
    else $error("ready pin high while busy");
  fifo_irq_a: assert property (fifo_err_o && fifo_err_en_i |-> !irq_out_low_o)
    else $error("range error without interrupt");
  cmd_irq_a: assert property (cmd_err_o && cmd_err_en_i |-> !irq_out_low_o)
    else $error("overrun without interrupt");
  fifo_clear_a: assert property ($fell(fifo_err_o) |-> !chip_select_n_i)
    else $error("range error cleared outside a read");
  cmd_clear_a: assert property ($fell(cmd_err_o) |-> !chip_select_n_i)
    else $error("overrun cleared outside a read");
  state_onehot_a: assert property ($onehot(radio_state_o))
    else $error("state not one-hot");
  tune_exit_a: assert property (radio_state_o == 5'h04 |=>
    radio_state_o inside {5'h01, 5'h04, 5'h08, 5'h10}) else $error("bad exit from tune");
  trx_return_a: assert property (!shutdown_pin_i [*4] ##0
    ((radio_state_o[3] || radio_state_o[4]) && trx_done_i) |=> radio_state_o == 5'h02)
    else $error("no return to ready");
endmodule // radio_spi_port_checker

bind radio_spi_command_port radio_spi_port_checker u_radio_spi_port_checker (
  .mclk_i, .rstn_i, .shutdown_pin_i, .chip_select_n_i, .serial_data_out_o,
  .serial_data_out_oe_o, .irq_out_low_o, .ready_pin_one_o, .cmd_valid_o, .rsp_done_i,
  .fifo_err_en_i, .cmd_err_en_i, .fifo_err_o, .cmd_err_o, .trx_done_i, .radio_state_o);
`default_nettype wire

//--- test/host_spi.sv
/*
  host model: spi mode 0 master, 64 ns clock that stands still between frames.
  assumes the bench calls one task at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module host_spi (
  output var logic cs_n_o,
  output var logic sck_o,
  output var logic mosi_o,
  input wire logic miso_i
);
  initial begin
    cs_n_o = 1'h1;
    sck_o = 1'h0;
    mosi_o = 1'h1;
  end
  task automatic start();
    #0.3;
    cs_n_o = 1'h0;
    #32;
  endtask
  task automatic stop();
    #32;
    cs_n_o = 1'h1;
    // released line flips so stale data cannot pass
    mosi_o = ~mosi_o;
    #64;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      #32;
      rx[i] = miso_i;
      sck_o = 1'h1;
      #32;
      sck_o = 1'h0;
    end
  endtask
endmodule // host_spi
`default_nettype wire

//--- test/tb.sv
/*
  self-checking bench for the serial command port; the bench plays the command core.
  assumes short timing parameters and the host model on the serial pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "radio_spi_map.vh"

module tb;
  localparam POR_C = 40, SD_C = 60, TX_C = 20, RX_C = 18;
  logic mclk_i = 1'h0, rstn_i = 1'h0, ce_i = 1'h1, shutdown_pin_i = 1'h1, rsp_done_i = 1'h0;
  logic ext_irq_i = 1'h0, fifo_err_en_i = 1'h1, cmd_err_en_i = 1'h1, tx_pop_i = 1'h0;
  logic rx_push_i = 1'h0, tx_req_i = 1'h0, rx_req_i = 1'h0, trx_done_i = 1'h0;
  logic [127:0] rsp_data_i = '0, rsp;
  logic [31:0] fast_status_select_i = '0;
  logic [63:0] status_items_i = '0;
  logic [7:0] rx_data_i = '0, rd[$], wq[$], txq[$], rxq[$];
  logic [7:0] fcode[4] = '{`CMD_FSR_A, `CMD_FSR_B, `CMD_FSR_C, `CMD_FSR_D};
  wire chip_select_n_i, spi_clk_i, serial_data_in_i, serial_data_out_o, serial_data_out_oe_o;
  wire irq_out_low_o, ready_pin_one_o, cmd_valid_o, fifo_err_o, cmd_err_o, tx_empty_o, rx_full_o;
  wire [7:0] cmd_byte_o, tx_data_o;
  wire [4:0] radio_state_o;
  int n_mismatch = 0, samples_checked = 0, n_cmd = 0, i, k;

  radio_spi_command_port #(.POR_CYCLES(POR_C), .SD_TRX_CYCLES(SD_C), .RDY_TX_CYCLES(TX_C),
    .RDY_RX_CYCLES(RX_C)) u_radio_spi_command_port (
    .mclk_i, .rstn_i, .ce_i, .shutdown_pin_i, .chip_select_n_i, .spi_clk_i, .serial_data_in_i,
    .serial_data_out_o, .serial_data_out_oe_o, .irq_out_low_o, .ready_pin_one_o, .cmd_valid_o,
    .cmd_byte_o, .param_valid_o(), .param_byte_o(), .rsp_done_i, .rsp_data_i,
    .fast_status_select_i, .status_items_i, .ext_irq_i, .fifo_err_en_i, .cmd_err_en_i,
    .fifo_err_o, .cmd_err_o, .tx_pop_i, .tx_data_o, .tx_empty_o, .rx_push_i, .rx_data_i,
    .rx_full_o, .tx_req_i, .rx_req_i, .trx_done_i, .radio_state_o);
  host_spi u_host_spi (.cs_n_o(chip_select_n_i), .sck_o(spi_clk_i),
    .mosi_o(serial_data_in_i), .miso_i(serial_data_out_o));

  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) if (cmd_valid_o === 1'h1) n_cmd++;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] rsp_byte(input int j);
    return rsp[8*j +: 8];
  endfunction
  function automatic logic [7:0] fsr_val(input int r);
    return status_items_i[8*fast_status_select_i[8*r +: 3] +: 8];
  endfunction
  task automatic core_done();
    rsp = {$urandom, $urandom, $urandom, $urandom};
    rsp_data_i = rsp;
    rsp_done_i = 1'h1;
    tick(1);
    rsp_done_i = 1'h0;
  endtask
  // one framed transaction: code, then n bytes from wq or random
  task automatic txn(input logic [7:0] c, input int n);
    logic [7:0] b;
    rd.delete();
    u_host_spi.start();
    u_host_spi.xfer(c, b);
    repeat (n) begin
      u_host_spi.xfer(wq.size() ? wq.pop_front() : 8'($urandom), b);
      rd.push_back(b);
    end
    u_host_spi.stop();
    tick(1);
  endtask
  // tune time depends on where the request starts
  task automatic seq(input logic tx, input logic [4:0] st);
    int n;
    int exp;
    exp = (radio_state_o == 5'h01 ? SD_C : (tx ? TX_C : RX_C));
    n = 0;
    {tx_req_i, rx_req_i} = {tx, ~tx};
    tick(1);
    {tx_req_i, rx_req_i} = 2'h0;
    for (int w = 0; w < 500 && radio_state_o !== st; w++) begin
      n += (radio_state_o == 5'h04);
      tick(1);
    end
    chk("tune_cycles", n, exp);
    trx_done_i = 1'h1;
    tick(2);
    trx_done_i = 1'h0;
    chk("back_to_ready", radio_state_o, 5'h02);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    void'($urandom(32'hf3ff4275));
    fast_status_select_i = $urandom;
    status_items_i = {$urandom, $urandom};
    tick(12);
    rstn_i = 1'h1;
    shutdown_pin_i = 1'h0;
    tick(POR_C / 2);
    chk("ready_in_por", ready_pin_one_o, 1'h0);
    for (i = 0; i < 200 && ready_pin_one_o !== 1'h1; i++) tick(1);
    chk("ready_after_por", ready_pin_one_o, 1'h1);
    chk("por_length", i >= POR_C / 2, 1'h1);
    seq(1'h1, 5'h08);
    seq(1'h0, 5'h10);
    txn(`CMD_INT_STATUS, 0);
    chk("cmd_code", cmd_byte_o, `CMD_INT_STATUS);
    txn(`CMD_READ_BUFF, 2);
    chk("cts_pending", rd[0], `CTS_PENDING);
    chk("ready_busy", ready_pin_one_o, 1'h0);
    core_done();
    txn(`CMD_READ_BUFF, 19);
    chk("cts_ready", rd[0], `CTS_READY);
    for (i = 1; i < 19; i++) chk("answer", rd[i], rsp_byte((i - 1) % 16));
    txn(`CMD_READ_BUFF, 3);
    chk("reread", rd[1], rsp_byte(0));
    for (i = 0; i < 4; i++) begin
      txn(fcode[i], 6);
      for (k = 0; k < 6; k++) chk("fast_status", rd[k], fsr_val((i + k) % 4));
    end
    for (i = 0; i < 65; i++) wq.push_back(8'($urandom));
    txq = wq;
    txn(`CMD_TX_WRITE, 65);
    chk("tx_overflow", fifo_err_o, 1'h1);
    chk("irq_on_error", irq_out_low_o, 1'h0);
    txn(`CMD_FSR_A, 4);
    chk("irq_after_fast", irq_out_low_o, 1'h0);
    tx_pop_i = 1'h1;
    for (i = 0; i < 64; i++) begin
      tick(1);
      chk("tx_data", tx_data_o, txq[i]);
    end
    tx_pop_i = 1'h0;
    chk("tx_empty", tx_empty_o, 1'h1);
    txn(`CMD_CHIP_STATUS, 0);
    core_done();
    txn(`CMD_READ_BUFF, 2);
    chk("err_cleared", fifo_err_o, 1'h0);
    chk("irq_released", irq_out_low_o, 1'h1);
    for (i = 0; i < 3; i++) begin
      rx_data_i = 8'($urandom);
      rxq.push_back(rx_data_i);
      rx_push_i = 1'h1;
      tick(1);
    end
    rx_push_i = 1'h0;
    txn(`CMD_RX_READ, 3);
    for (i = 0; i < 3; i++) chk("rx_data", rd[i], rxq[i]);
    chk("rx_exact_no_err", fifo_err_o, 1'h0);
    txn(`CMD_RX_READ, 1);
    chk("rx_underflow", fifo_err_o, 1'h1);
    k = n_cmd;
    txn(8'h31, 0);
    txn(8'h32, 0);
    chk("overrun_flag", cmd_err_o, 1'h1);
    chk("overrun_dropped", n_cmd - k, 1);
    core_done();
    txn(`CMD_INT_STATUS, 0);
    core_done();
    txn(`CMD_READ_BUFF, 2);
    chk("overrun_cleared", cmd_err_o, 1'h0);
    shutdown_pin_i = 1'h1;
    tick(8);
    chk("sd_state", radio_state_o, 5'h01);
    chk("sd_ready_low", ready_pin_one_o, 1'h0);
    shutdown_pin_i = 1'h0;
    tick(POR_C + 8);
    chk("ready_after_wake", ready_pin_one_o, 1'h1);
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge mclk_i);
    n_mismatch++;
    finish_test();
  end
endmodule // tb
`default_nettype wire
